// ==== src/ces_exception_sequencer.sv ====
/*
 * Exception sequencer: collects pending exceptions, arbitrates them by
 * priority, builds short frames on the supervisor stack, fetches vectors
 * and hands the core a new program counter. Registers sit on apb.
 * Assumes the exception bus is synchronous to clk_in and that the core
 * stalls while core_hold_out is high.
 */
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module ces_exception_sequencer
   import ces_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // apb slave
   input wire logic [7:0] paddr_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // exception sources from the core
   input wire logic reset_req_in,
   input wire logic boundary_in,
   input wire logic fetch_req_in,
   input wire logic fetch_lsb_in,
   input wire logic opnd_req_in,
   input wire logic opnd_lsb_in,
   input wire logic [1:0] opnd_size_in,
   input wire logic bus_fault_in,
   input wire logic trap_req_in,
   input wire logic [7:0] trap_vec_in,
   input wire logic ill_op_in,
   input wire logic [7:0] ill_vec_in,
   input wire logic priv_viol_in,
   // asynchronous pins
   input wire logic hw_breakpoint_instruction_in,
   input wire logic [2:0] irq_level_in,
   // exception bus master
   output logic bus_req_out,
   output logic bus_we_out,
   output logic [31:0] bus_addr_out,
   output logic [31:0] bus_wdata_out,
   output logic [2:0] function_code_out,
   input wire logic [31:0] bus_rdata_in,
   input wire logic bus_ack_in,
   input wire logic bus_err_in,
   // core control
   output logic core_hold_out,
   output logic handler_go_out,
   output logic halted_out,
   output logic [31:0] pc_out
);
   //***************************************************
   // declarations
   //***************************************************
   ces_state_e state_q, state_d, sst_q, sst_d;
   logic [15:0] sr_q, sr_d, snap_q, snap_d, ssnap_q, ssnap_d;
   logic [31:0] vbr_q, vbr_d, pc_q, pc_d, ssp_q, ssp_d;
   logic [NPEND-1:0] pend_q, pend_d, pend_set, pend_clr, pend_keep, elig;
   logic [2:0] idx_q, idx_d, sidx_q, sidx_d, lvl_q, lvl_d;
   logic [7:0] vec_q, vec_d, svec_q, svec_d, trap_vq, ill_vq;
   logic step_q, step_d, sstep_q, sstep_d, susp_q, susp_d, go_d;
   logic bp_s1, bp_s2, bp_s3, boundary_q;
   logic [2:0] irq_s1, irq_s2;
   logic odd_fetch, odd_opnd, bp_rise, irq_live, grp4_ok, sel_any;
   logic [2:0] sel_idx;
   logic is_rst, is_irq, in_bus, bus_done, berr_hit, berr_halt, req_d;
   logic [31:0] vec_off, fetch_addr, push_addr, frame_lo, frame_hi;
   logic [31:0] addr_c, wdata_c, rd_c;
   logic [2:0] fc_c;
   logic apb_setup, apb_wr, idle, mapped;
   logic hit_vbr, hit_sr, hit_pc, hit_ssp, hit_stat, hit_snap;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q, req_q, we_q, hold_q, go_q, halt_q;
   logic [31:0] addr_q, wdata_q;
   logic [2:0] fc_q;

   // lowest set index wins, so reset beats everything
   function automatic logic [2:0] first_one(input logic [NPEND-1:0] v);
      first_one = 3'h0;
      for (int i = NPEND - 1; i >= 0; i--)
         if (v[i])
            first_one = 3'(i);
   endfunction

   // internal vector number for each slot; irq comes from the bus
   function automatic logic [7:0] vec_of(input logic [2:0] i);
      case (i)
         P_ADDR: vec_of = VEC_ADDR;
         P_BUS: vec_of = VEC_BUS;
         P_TRAP: vec_of = trap_vq;
         P_ILL: vec_of = ill_vq;
         P_TRACE: vec_of = VEC_TRACE;
         P_BREAKPOINT_INSTRUCTION: vec_of = VEC_HWBP;
         default: vec_of = VEC_RST;
      endcase
   endfunction

   //***************************************************
   // pin synchronisers
   //***************************************************
   always_ff @(posedge clk_in)
   begin
      bp_s1 <= rst_in ? 1'b0 : hw_breakpoint_instruction_in;
      bp_s2 <= rst_in ? 1'b0 : bp_s1;
      bp_s3 <= rst_in ? 1'b0 : bp_s2;
      irq_s1 <= rst_in ? 3'h0 : irq_level_in;
      irq_s2 <= rst_in ? 3'h0 : irq_s1;
   end

   //***************************************************
   // pending exceptions
   //***************************************************
   // sources; set always beats the clear of the same cycle
   assign odd_fetch = fetch_req_in & fetch_lsb_in;
   assign odd_opnd = opnd_req_in & opnd_lsb_in & (opnd_size_in != SIZE_BYTE);
   assign bp_rise = bp_s2 & ~bp_s3;
   assign irq_live = irq_s2 > sr_q[IPM_HI:IPM_LO];
   assign pend_set = {1'b0, bp_rise, boundary_in & sr_q[SR_T1],
                      ill_op_in | priv_viol_in, trap_req_in,
                      bus_fault_in, odd_fetch | odd_opnd, reset_req_in};
   assign pend_keep = (pend_q & ~pend_clr) | pend_set;
   // a reset request wipes every other pending slot
   assign pend_d = reset_req_in ? RST_ONLY
                   : {irq_live, pend_keep[NPEND-2:0]};
   // group four goes one cycle after a boundary, so that a trace raised
   // by that same boundary is already pending and is taken before an interrupt
   assign grp4_ok = boundary_q | (state_q == S_LOAD);
   assign elig = pend_q & (grp4_ok ? {NPEND{1'b1}} : ~GRP4_MASK);
   assign sel_any = |elig;
   assign sel_idx = first_one(elig);

   // latched vector numbers of the decoder-raised exceptions and boundary
   always_ff @(posedge clk_in)
   begin
      boundary_q <= ~rst_in & boundary_in;
      trap_vq <= rst_in ? VEC_RST : trap_req_in ? trap_vec_in : trap_vq;
      ill_vq <= rst_in ? VEC_RST : ill_op_in ? ill_vec_in
                : priv_viol_in ? VEC_PRIV : ill_vq;
   end

   //***************************************************
   // exception bus datapath
   //***************************************************
   assign is_rst = idx_q == P_RST;
   assign is_irq = idx_q == P_IRQ;
   assign in_bus = state_q inside {S_IACK, S_PUSH, S_VFETCH};
   assign bus_done = req_q & (bus_ack_in | bus_err_in);
   assign berr_hit = req_q & bus_err_in & (state_q != S_IACK);
   // a fault while serving a fault or reset cannot be recovered
   assign berr_halt = susp_q | (idx_q == P_RST) | (idx_q == P_ADDR)
                      | (idx_q == P_BUS);
   // the 8-bit number bounds the table to 256 long words
   assign vec_off = 32'(vec_q) << VEC_SHIFT;
   assign fetch_addr = vbr_q + vec_off + (step_q ? LONG_BYTES : VBR_RST);
   assign push_addr = ssp_q - (step_q ? FRAME_BYTES : LONG_BYTES);
   assign frame_lo = {pc_q[15:0], FMT_SHORT, vec_off[11:0]};
   assign frame_hi = {snap_q, pc_q[31:16]};
   assign addr_c = (state_q == S_IACK) ? {IACK_HI, lvl_q, 1'b1}
                   : (state_q == S_PUSH) ? push_addr : fetch_addr;
   assign wdata_c = step_q ? frame_hi : frame_lo;
   assign fc_c = (state_q == S_IACK) ? FC_CPU
                 : (is_rst ? FC_SP : FC_SD);
   // the request drops for a cycle between two accesses
   assign req_d = in_bus & (state_d == state_q) & ~bus_done;

   //***************************************************
   // sequencer
   //***************************************************
   always_comb
   begin
      state_d = state_q;
      sr_d = (apb_wr & hit_sr & idle) ? pwdata_in[15:0] : sr_q;
      vbr_d = (apb_wr & hit_vbr & idle) ? pwdata_in : vbr_q;
      pc_d = (apb_wr & hit_pc & idle) ? pwdata_in : pc_q;
      ssp_d = (apb_wr & hit_ssp & idle) ? pwdata_in : ssp_q;
      snap_d = snap_q;
      idx_d = idx_q;
      vec_d = vec_q;
      step_d = step_q;
      lvl_d = lvl_q;
      susp_d = susp_q;
      sst_d = sst_q;
      sstep_d = sstep_q;
      sidx_d = sidx_q;
      svec_d = svec_q;
      ssnap_d = ssnap_q;
      pend_clr = '0;
      go_d = 1'b0;
      if (pend_q[P_RST])
      begin
         // abandon whatever runs, nothing is saved
         state_d = S_ENTRY;
         idx_d = P_RST;
         vec_d = VEC_RST;
         susp_d = 1'b0;
         pend_clr = '1;
      end
      else if (berr_hit)
      begin
         if (berr_halt)
            state_d = S_HALT;
         else
         begin
            // park the running sequence and serve the bus error first
            susp_d = 1'b1;
            sst_d = state_q;
            sstep_d = step_q;
            sidx_d = idx_q;
            svec_d = vec_q;
            ssnap_d = snap_q;
            idx_d = P_BUS;
            vec_d = VEC_BUS;
            state_d = S_ENTRY;
         end
      end
      else
         case (state_q)
            S_IDLE, S_LOAD:
            begin
               if (state_q == S_LOAD && susp_q)
               begin
                  state_d = sst_q;
                  step_d = sstep_q;
                  idx_d = sidx_q;
                  vec_d = svec_q;
                  snap_d = ssnap_q;
                  susp_d = 1'b0;
               end
               else if (sel_any)
               begin
                  state_d = S_ENTRY;
                  idx_d = sel_idx;
                  vec_d = vec_of(sel_idx);
                  lvl_d = irq_s2;
                  pend_clr = RST_ONLY << sel_idx;
               end
               else if (state_q == S_LOAD)
               begin
                  state_d = S_IDLE;
                  go_d = 1'b1;
               end
            end
            S_ENTRY:
            begin
               snap_d = sr_q;
               sr_d[SR_S] = 1'b1;
               sr_d[SR_T1] = 1'b0;
               sr_d[SR_T0] = 1'b0;
               step_d = 1'b0;
               state_d = S_PUSH;
               if (is_rst)
               begin
                  sr_d = SR_RST;
                  vbr_d = VBR_RST;
                  state_d = S_VFETCH;
               end
               else if (is_irq)
               begin
                  sr_d[IPM_HI:IPM_LO] = lvl_q;
                  state_d = S_IACK;
               end
            end
            S_IACK:
               if (bus_done)
               begin
                  // an error ending the acknowledge cycle means a spurious interrupt
                  vec_d = bus_err_in ? VEC_SPUR : bus_rdata_in[7:0];
                  state_d = S_PUSH;
               end
            S_PUSH:
               if (bus_done)
               begin
                  step_d = ~step_q;
                  if (step_q)
                  begin
                     ssp_d = push_addr;
                     state_d = S_VFETCH;
                  end
               end
            S_VFETCH:
               if (bus_done)
               begin
                  if (is_rst & ~step_q)
                  begin
                     ssp_d = bus_rdata_in;
                     step_d = 1'b1;
                  end
                  else
                  begin
                     pc_d = bus_rdata_in;
                     state_d = S_LOAD;
                  end
               end
            S_HALT:
               state_d = S_HALT;
            default:
               state_d = S_IDLE;
         endcase
   end

   // sequencer state; a fresh reset runs the reset exception
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         state_q <= S_IDLE;
         sst_q <= S_IDLE;
         pend_q <= RST_ONLY;
         {sr_q, snap_q, ssnap_q} <= {SR_RST, 16'h0000, 16'h0000};
         {vbr_q, pc_q, ssp_q} <= {VBR_RST, 32'h0, 32'h0};
         {idx_q, sidx_q, lvl_q} <= 9'h000;
         {vec_q, svec_q} <= 16'h0000;
         {step_q, sstep_q, susp_q} <= 3'h0;
      end
      else
      begin
         state_q <= state_d;
         sst_q <= sst_d;
         pend_q <= pend_d;
         {sr_q, snap_q, ssnap_q} <= {sr_d, snap_d, ssnap_d};
         {vbr_q, pc_q, ssp_q} <= {vbr_d, pc_d, ssp_d};
         {idx_q, sidx_q, lvl_q} <= {idx_d, sidx_d, lvl_d};
         {vec_q, svec_q} <= {vec_d, svec_d};
         {step_q, sstep_q, susp_q} <= {step_d, sstep_d, susp_d};
      end
   end

   // registered outputs towards bus and core
   always_ff @(posedge clk_in)
   begin
      req_q <= ~rst_in & req_d;
      we_q <= ~rst_in & (state_q == S_PUSH);
      addr_q <= rst_in ? 32'h0 : addr_c;
      wdata_q <= rst_in ? 32'h0 : wdata_c;
      fc_q <= rst_in ? FC_SD : fc_c;
      hold_q <= ~rst_in & (state_d != S_IDLE);
      go_q <= ~rst_in & go_d;
      halt_q <= ~rst_in & (state_d == S_HALT);
   end

   //***************************************************
   // apb slave, answers one cycle after setup
   //***************************************************
   assign idle = state_q == S_IDLE; // software edits only a quiet unit
   assign apb_setup = psel_in & ~penable_in;
   assign apb_wr = psel_in & penable_in & pready_q & pwrite_in;
   assign hit_vbr = paddr_in == REG_VBR;
   assign hit_sr = paddr_in == REG_SR;
   assign hit_pc = paddr_in == REG_PC;
   assign hit_ssp = paddr_in == REG_SSP;
   assign hit_stat = paddr_in == REG_STAT;
   assign hit_snap = paddr_in == REG_SNAP;
   assign mapped = |{hit_vbr, hit_sr, hit_pc, hit_ssp, hit_stat, hit_snap};
   assign rd_c = hit_vbr ? vbr_q : hit_sr ? {16'h0000, sr_q}
                 : hit_pc ? pc_q : hit_ssp ? ssp_q
                 : hit_stat ? {8'h00, susp_q, state_q, vec_q, pend_q}
                 : hit_snap ? {16'h0000, snap_q} : 32'h0;
   always_ff @(posedge clk_in)
   begin
      pready_q <= ~rst_in & apb_setup;
      pslverr_q <= ~rst_in & apb_setup & ~mapped;
      prdata_q <= (rst_in | ~apb_setup) ? 32'h0 : rd_c;
   end

   assign prdata_out = prdata_q;
   assign pready_out = pready_q;
   assign pslverr_out = pslverr_q;
   assign bus_req_out = req_q;
   assign bus_we_out = we_q;
   assign bus_addr_out = addr_q;
   assign bus_wdata_out = wdata_q;
   assign function_code_out = fc_q;
   assign core_hold_out = hold_q;
   assign handler_go_out = go_q;
   assign halted_out = halt_q;
   assign pc_out = pc_q;

   //***************************************************
   // assertions
   //***************************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   fc_data_a:
      assert property (req_q && state_q == S_VFETCH && !is_rst
         |-> function_code_out == FC_SD) else $error("vector fc wrong");
   fc_prog_a:
      assert property (req_q && state_q == S_VFETCH && is_rst
         |-> function_code_out == FC_SP
         && bus_addr_out == {29'h0, step_q, 2'b00})
         else $error("reset fetch wrong");
   vec_addr_a:
      assert property (req_q && state_q == S_VFETCH && !is_rst
         |-> bus_addr_out == vbr_q + {22'h0, vec_q, 2'b00})
         else $error("vector address wrong");
   iack_a:
      assert property (req_q && state_q == S_IACK
         |-> function_code_out == FC_CPU && bus_addr_out[3:1] == lvl_q)
         else $error("acknowledge cycle wrong");
   entry_sr_a:
      assert property (state_q == S_ENTRY && !is_rst && !pend_q[P_RST]
         |=> sr_q[SR_S] && !sr_q[SR_T1] && !sr_q[SR_T0]
         && snap_q == $past(sr_q)) else $error("entry status wrong");
   ipm_keep_a:
      assert property (state_q == S_ENTRY && !is_rst && !is_irq
         && !pend_q[P_RST] |=> $stable(sr_q[IPM_HI:IPM_LO]))
         else $error("mask changed");
   frame_lo_a:
      assert property (req_q && state_q == S_PUSH && !step_q
         |-> bus_we_out && bus_wdata_out[15:12] == FMT_SHORT
         && bus_wdata_out[11:0] == {2'b00, vec_q, 2'b00})
         else $error("frame format wrong");
   frame_hi_a:
      assert property (req_q && state_q == S_PUSH && step_q
         |-> bus_wdata_out[31:16] == snap_q) else $error("frame sr wrong");
   resume_a:
      assert property (state_q == S_LOAD && !susp_q && !sel_any
         && !pend_q[P_RST] |=> handler_go_out ##1 !handler_go_out)
         else $error("resume pulse wrong");
   rst_first_a:
      assert property (reset_req_in |=> ##1 state_q == S_ENTRY && is_rst)
         else $error("reset not first");
   rst_regs_a:
      assert property (state_q == S_ENTRY && is_rst && !pend_q[P_RST]
         |=> vbr_q == VBR_RST && sr_q[IPM_HI:IPM_LO] == IPM_MAX)
         else $error("reset values wrong");
   odd_a:
      assert property (odd_fetch |=> pend_q[P_ADDR] || pend_q[P_RST])
         else $error("odd fetch lost");
   grp4_a:
      assert property (state_q == S_IDLE && !boundary_q
         && (pend_q & ~GRP4_MASK) == 8'h00 |=> state_q == S_IDLE)
         else $error("group four started early");
   berr_a:
      assert property (berr_hit && !berr_halt && !pend_q[P_RST]
         |=> state_q == S_ENTRY && susp_q && vec_q == VEC_BUS)
         else $error("bus error not nested");
   irq_c: cover property (state_q == S_IACK && bus_done);
   chain_c: cover property (state_q == S_LOAD && sel_any && !susp_q);
   nest_c: cover property (state_q == S_LOAD && susp_q);
   halt_c: cover property (state_q == S_HALT);
endmodule
`default_nettype wire

// ==== pkg/ces_pkg.sv ====
/*
 * Constants and types shared by the exception sequencer: register
 * offsets, status word fields, vector numbers, function codes and states.
 * Assumes a 32-bit address space and a 16-bit status word.
 */
package ces_pkg;
   //***************************************************
   // register offsets (byte addresses on the apb side)
   //***************************************************
   localparam logic [7:0] REG_VBR = 8'h00;
   localparam logic [7:0] REG_SR = 8'h04;
   localparam logic [7:0] REG_PC = 8'h08;
   localparam logic [7:0] REG_SSP = 8'h0c;
   localparam logic [7:0] REG_STAT = 8'h10;
   localparam logic [7:0] REG_SNAP = 8'h14;
   //***************************************************
   // status word fields and reset values
   //***************************************************
   localparam int SR_T1 = 15;
   localparam int SR_T0 = 14;
   localparam int SR_S = 13;
   localparam int IPM_HI = 10;
   localparam int IPM_LO = 8;
   localparam logic [15:0] SR_RST = 16'h2700;
   localparam logic [2:0] IPM_MAX = 3'h7;
   localparam logic [31:0] VBR_RST = 32'h0000_0000;
   //***************************************************
   // vectors, frame and bus constants
   //***************************************************
   localparam logic [7:0] VEC_RST = 8'h00;
   localparam logic [7:0] VEC_BUS = 8'h02;
   localparam logic [7:0] VEC_ADDR = 8'h03;
   localparam logic [7:0] VEC_PRIV = 8'h08;
   localparam logic [7:0] VEC_TRACE = 8'h09;
   localparam logic [7:0] VEC_HWBP = 8'h0c;
   localparam logic [7:0] VEC_SPUR = 8'h18;
   localparam int VEC_SHIFT = 2;
   localparam logic [3:0] FMT_SHORT = 4'h0;
   localparam logic [31:0] LONG_BYTES = 32'h0000_0004;
   localparam logic [31:0] FRAME_BYTES = 32'h0000_0008;
   localparam logic [2:0] FC_SD = 3'h5;
   localparam logic [2:0] FC_SP = 3'h6;
   localparam logic [2:0] FC_CPU = 3'h7;
   localparam logic [27:0] IACK_HI = 28'hfff_ffff;
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   //***************************************************
   // pending slots, lowest index is highest priority
   //***************************************************
   localparam int NPEND = 8;
   localparam logic [2:0] P_RST = 3'h0;
   localparam logic [2:0] P_ADDR = 3'h1;
   localparam logic [2:0] P_BUS = 3'h2;
   localparam logic [2:0] P_TRAP = 3'h3;
   localparam logic [2:0] P_ILL = 3'h4;
   localparam logic [2:0] P_TRACE = 3'h5;
   localparam logic [2:0] P_BREAKPOINT_INSTRUCTION = 3'h6;
   localparam logic [2:0] P_IRQ = 3'h7;
   localparam logic [7:0] RST_ONLY = 8'h01;
   localparam logic [7:0] GRP4_MASK = 8'he0;
   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_ENTRY = 7'h02,
      S_IACK = 7'h04,
      S_PUSH = 7'h08,
      S_VFETCH = 7'h10,
      S_LOAD = 7'h20,
      S_HALT = 7'h40
   } ces_state_e;
endpackage

// ==== verif/ces_bus_partner.sv ====
/*
 * Far-side model of the exception bus: memory holding handler addresses
 * and an interrupting peripheral that answers acknowledge cycles.
 * Assumes one request at a time, held until acknowledged.
 */
`timescale 1ns/100ps
`default_nettype none
module ces_bus_partner
(
   // clock and latency choice
   input wire logic clk_in,
   input wire logic slow_in,
   // request side
   input wire logic bus_req_in,
   input wire logic [31:0] bus_addr_in,
   input wire logic [2:0] function_code_in,
   // answer side
   output logic [31:0] bus_rdata_out = 32'h0,
   output logic bus_ack_out = 1'h0,
   output logic bus_err_out
);
   logic [1:0] wait_q = 2'h0;
   // never errors: no scenario asks for a faulty termination
   assign bus_err_out = 1'h0;
   // answer after 0 or 3 wait cycles; data toggles when not answering
   always_ff @(posedge clk_in)
   begin
      wait_q <= (!bus_req_in || bus_ack_out) ? 2'h0 : wait_q + 2'h1;
      bus_ack_out <= bus_req_in && !bus_ack_out && (!slow_in || wait_q == 2'h3);
      if (bus_req_in && !bus_ack_out && function_code_in == 3'h7)
         bus_rdata_out <= 32'h0000_0040;
      else if (bus_req_in && !bus_ack_out)
         bus_rdata_out <= bus_addr_in + 32'h0001_0000;
      else
         bus_rdata_out <= ~bus_rdata_out;
   end
endmodule
`default_nettype wire

// ==== verif/cpu_exception_sequencer_tb_top.sv ====
/*
 * Self-checking bench: reset, trap, trace with interrupt, odd fetch,
 * reset request in the middle of a trap.
 * Assumes the bus partner model beside the design.
 */
`timescale 1ns/100ps
`default_nettype none
module cpu_exception_sequencer_tb_top
   import ces_pkg::*;
;
   logic clk_in = 1'h0, rst_in = 1'h1, psel_in = 1'h0, penable_in = 1'h0;
   logic pwrite_in = 1'h0, reset_req_in = 1'h0, boundary_in = 1'h0;
   logic fetch_req_in = 1'h0, fetch_lsb_in = 1'h0, opnd_req_in = 1'h0;
   logic opnd_lsb_in = 1'h0, bus_fault_in = 1'h0, trap_req_in = 1'h0;
   logic ill_op_in = 1'h0, priv_viol_in = 1'h0, hw_breakpoint_instruction_in = 1'h0;
   logic slow = 1'h0, pready_out, pslverr_out, bus_req_out, bus_we_out;
   logic bus_ack_in, bus_err_in, core_hold_out, handler_go_out, halted_out;
   logic [7:0] paddr_in = 8'h0, trap_vec_in = 8'h0, ill_vec_in = 8'h0;
   logic [1:0] opnd_size_in = 2'h0;
   logic [2:0] irq_level_in = 3'h0, function_code_out;
   logic [31:0] pwdata_in = 32'h0, prdata_out, bus_addr_out, bus_wdata_out;
   logic [31:0] bus_rdata_in, pc_out, r;
   logic e;
   logic [3:0] fq[$];
   logic [31:0] ad[$], wd[$];
   int failures = 0, tests_run = 0, cyc = 0, n;
   ces_exception_sequencer DUT (.clk_in, .rst_in, .paddr_in, .psel_in,
      .penable_in, .pwrite_in, .pwdata_in, .prdata_out, .pready_out,
      .pslverr_out, .reset_req_in, .boundary_in, .fetch_req_in,
      .fetch_lsb_in, .opnd_req_in, .opnd_lsb_in, .opnd_size_in, .bus_fault_in,
      .trap_req_in, .trap_vec_in, .ill_op_in, .ill_vec_in, .priv_viol_in,
      .hw_breakpoint_instruction_in, .irq_level_in, .bus_req_out, .bus_we_out, .bus_addr_out,
      .bus_wdata_out, .function_code_out, .bus_rdata_in, .bus_ack_in,
      .bus_err_in, .core_hold_out, .handler_go_out, .halted_out, .pc_out);
   ces_bus_partner PARTNER (.clk_in, .slow_in(slow), .bus_req_in(bus_req_out),
      .bus_addr_in(bus_addr_out), .function_code_in(function_code_out),
      .bus_rdata_out(bus_rdata_in), .bus_ack_out(bus_ack_in),
      .bus_err_out(bus_err_in));
   //*****************************************
   // clock, transfer log, hang guard
   //*****************************************
   initial
   begin
      forever #25 clk_in = ~clk_in;
   end
   always @(posedge clk_in)
   begin
      cyc++;
      if (bus_req_out === 1'h1 && bus_ack_in === 1'h1)
      begin
         fq.push_back({bus_we_out, function_code_out});
         ad.push_back(bus_addr_out);
         wd.push_back(bus_wdata_out);
      end
      if (cyc == 5000)
      begin
         failures++;
         give_verdict();
      end
   end
   //*****************************************
   // shared tasks
   //*****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         failures++;
         $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one logged transfer: direction, function code, address, push data
   task automatic xb(input int i, input logic [2:0] f, input logic [31:0] a,
                     input logic [31:0] d);
      check({28'h0, fq[n+i]}, {28'h0, d != 32'h0, f});
      check(ad[n+i], a);
      if (f == FC_SD && d != 32'h0)
         check(wd[n+i], d);
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk_in);
      psel_in <= 1'h1;
      penable_in <= 1'h0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'h1;
      // answer is taken at the edge that ends the access, then released
      do @(posedge clk_in); while (pready_out !== 1'h1);
      r = prdata_out;
      e = pslverr_out;
      psel_in <= 1'h0;
      penable_in <= 1'h0;
   endtask
   // wait for the handler start pulse, seen mid-cycle
   task automatic go();
      while (handler_go_out !== 1'h1) @(negedge clk_in);
      @(posedge clk_in);
   endtask
   //*****************************************
   // scenarios
   //*****************************************
   task automatic t_reset();
      n = 0;
      go();
      xb(0, FC_SP, 32'h0, 32'h0);
      xb(1, FC_SP, 32'h4, 32'h0);
      check(pc_out, 32'h0001_0004);
      apb(1'h0, REG_SR, 32'h0);
      check(r, 32'h2700);
      apb(1'h0, REG_VBR, 32'h0);
      check(r, 32'h0);
   endtask
   task automatic t_trap();
      apb(1'h1, REG_VBR, 32'h1000);
      slow <= 1'h1;
      n = ad.size();
      trap_vec_in <= 8'h25;
      trap_req_in <= 1'h1;
      @(posedge clk_in);
      trap_req_in <= 1'h0;
      go();
      xb(0, FC_SD, 32'hfffc, 32'h0004_0094);
      xb(1, FC_SD, 32'hfff8, 32'h2700_0001);
      xb(2, FC_SD, 32'h1094, 32'h0);
      check(pc_out, 32'h0001_1094);
   endtask
   task automatic t_trace_irq();
      apb(1'h1, REG_SR, 32'hc000);
      n = ad.size();
      irq_level_in <= 3'h5;
      boundary_in <= 1'h1;
      @(posedge clk_in);
      boundary_in <= 1'h0;
      go();
      irq_level_in <= 3'h0;
      xb(0, FC_SD, 32'hfff4, 32'h1094_0024);
      xb(1, FC_SD, 32'hfff0, 32'hc000_0001);
      xb(2, FC_SD, 32'h1024, 32'h0);
      xb(3, FC_CPU, 32'hffff_fffb, 32'h0);
      xb(4, FC_SD, 32'hffec, 32'h1024_0100);
      xb(5, FC_SD, 32'hffe8, 32'h2000_0001);
      xb(6, FC_SD, 32'h1100, 32'h0);
      check(pc_out, 32'h0001_1100);
      apb(1'h0, REG_SR, 32'h0);
      check(r, 32'h2500);
   endtask
   task automatic t_odd_fetch();
      n = ad.size();
      fetch_lsb_in <= 1'h1;
      fetch_req_in <= 1'h1;
      @(posedge clk_in);
      fetch_req_in <= 1'h0;
      go();
      xb(0, FC_SD, 32'hffe4, 32'h1100_000c);
      xb(1, FC_SD, 32'hffe0, 32'h2500_0001);
      xb(2, FC_SD, 32'h100c, 32'h0);
      check(pc_out, 32'h0001_100c);
      apb(1'h0, 8'h18, 32'h0);
      check(r, 32'h0);
      check({31'h0, e}, 32'h1);
   endtask
   // reset request aborts a trap half way; vector base falls back to zero
   task automatic t_reset_req();
      trap_vec_in <= 8'h30;
      trap_req_in <= 1'h1;
      @(posedge clk_in);
      trap_req_in <= 1'h0;
      repeat (4) @(posedge clk_in);
      check({31'h0, core_hold_out}, 32'h1);
      reset_req_in <= 1'h1;
      @(posedge clk_in);
      reset_req_in <= 1'h0;
      go();
      n = ad.size() - 2;
      xb(0, FC_SP, 32'h0, 32'h0);
      xb(1, FC_SP, 32'h4, 32'h0);
      check(pc_out, 32'h0001_0004);
      check({30'h0, core_hold_out, halted_out}, 32'h0);
      apb(1'h0, REG_VBR, 32'h0);
      check(r, 32'h0);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge clk_in);
      rst_in <= 1'h0;
      t_reset();
      t_trap();
      t_trace_irq();
      t_odd_fetch();
      t_reset_req();
      give_verdict();
   end
endmodule
`default_nettype wire
